// [verilog/srb_pkg.sv]
// constants and types for the serial port readback block
`default_nettype none
package srb_pkg;

	// ========================================================
	// frame layout
	localparam int unsigned ADDR_W = 6;
	localparam int unsigned DATA_W = 24;
	localparam int unsigned CNT_W  = 6;
	// rising-edge count before the edge: edge k sees count k-1
	localparam logic [CNT_W-1:0] LAST_ADDR_COUNT  = 6'h06;
	localparam logic [CNT_W-1:0] FIRST_DATA_COUNT = 6'h07;
	localparam logic [CNT_W-1:0] LAST_DATA_COUNT  = 6'h1e;
	localparam logic [CNT_W-1:0] COMPLETE_COUNT   = 6'h1f;

	// ========================================================
	// register map
	localparam logic [ADDR_W-1:0] ADDR_IDENTITY = 6'h00;
	localparam logic [ADDR_W-1:0] ADDR_MUX_CFG  = 6'h1a;
	localparam logic [DATA_W-1:0] MUX_CFG_RESET = 24'h000000;
	localparam logic [DATA_W-1:0] READ_UNMAPPED = 24'h000000;
	localparam int unsigned AUTO_PIN_SHARE_BIT  = 12;
	localparam int unsigned LOCK_ONLY_BIT       = 13;
	localparam int unsigned SOFT_RESET_REGS_BIT = 0;

	// ========================================================
	// types
	typedef enum logic [3:0]
	{
		PH_IDLE = 4'b0001,
		PH_ADDR = 4'b0010,
		PH_DATA = 4'b0100,
		PH_DONE = 4'b1000
	} srb_phase_t;

	// shared pin drive: oe is low while the block drives the pin
	typedef struct packed
	{
		logic level;
		logic oe_n;
	} srb_pin_t;

	typedef struct packed
	{
		logic [2:0]        sclkSync;
		logic [1:0]        selSync;
		logic [1:0]        sdiSync;
		logic [1:0]        lockSync;
		srb_phase_t        phase;
		logic [CNT_W-1:0]  bitCount;
		logic              isRead;
		logic              readActive;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] shift;
		logic              dataBit;
		logic [DATA_W-1:0] muxCfg;
		logic              softResetPulse;
		srb_pin_t          pin;
	} srb_state_t;

endpackage
`default_nettype wire

// [verilog/srb_serial_port.sv]
// four-wire serial port slave with shared lock/readback output pin
//
// Function
// - cfg bits 12 auto-share, 13 lock-only select pin
// - both bits clear: pin is readback only
// - auto-share: pin to readback on read request
// - lock-only: pin shows lock, reads impossible
// - first rising edge samples sdi; high means read
// - address captured on rising edges two to seven
// - 24 data bits driven on rising edges 8-31
// - read completes at 32nd falling edge
// - address zero reads fixed 24-bit identity
// - strobe bit 0 at address zero resets registers
// - low first bit writes; 32nd rise completes
// - each register has its own access type
`timescale 1ns/10ps
`default_nettype none
module srb_serial_port
#(
	// arbitrary neutral identity value
	parameter logic [23:0] IDENTITY_VALUE = 24'h0a5c3e
)
(
	input  wire logic                    ref_clk,
	input  wire logic                    srst,
	input  wire logic                    serialClock,
	input  wire logic                    serial_select,
	input  wire logic                    serialDataIn,
	input  wire logic                    lock_detect_state,
	output var  logic                    lock_or_readback_pin,
	output var  logic                    lockOrReadbackPinOe_n,
	output var  logic                    softResetPulse,
	output var  logic [srb_pkg::DATA_W-1:0] muxConfig
);
	import srb_pkg::*;

	// ========================================================
	// state
	srb_state_t cur;
	srb_state_t next_state;

	logic sclkRise;
	logic sclkFall;
	logic selLive;
	logic sdiLive;
	logic autoShare;
	logic lockOnly;
	logic [DATA_W-1:0] readValue;

	// synchronised views of the pins, second stage onward only
	assign sclkRise  = cur.sclkSync[1] & ~cur.sclkSync[2];
	assign sclkFall  = ~cur.sclkSync[1] & cur.sclkSync[2];
	assign selLive   = cur.selSync[1];
	assign sdiLive   = cur.sdiSync[1];
	assign autoShare = cur.muxCfg[AUTO_PIN_SHARE_BIT];
	assign lockOnly  = cur.muxCfg[LOCK_ONLY_BIT];

	// ========================================================
	// read mux: identity at zero, config register, else zero
	always_comb
	begin
		if (cur.addr == ADDR_IDENTITY)
			readValue = IDENTITY_VALUE;
		else if (cur.addr == ADDR_MUX_CFG)
			readValue = cur.muxCfg;
		else
			readValue = READ_UNMAPPED;
	end

	// ========================================================
	// next state
	always_comb
	begin
		next_state = cur;
		next_state.sclkSync = {cur.sclkSync[1:0], serialClock};
		next_state.selSync  = {cur.selSync[0], serial_select};
		next_state.sdiSync  = {cur.sdiSync[0], serialDataIn};
		next_state.lockSync = {cur.lockSync[0], lock_detect_state};
		next_state.softResetPulse = 1'b0;

		// strobe one cycle later returns registers to reset
		if (cur.softResetPulse)
			next_state.muxCfg = MUX_CFG_RESET;

		if (!selLive)
		begin
			// select dropped: abandon any frame
			next_state.phase      = PH_IDLE;
			next_state.bitCount   = '0;
			next_state.readActive = 1'b0;
		end
		else
		begin
			case (cur.phase)
				PH_IDLE:
				begin
					if (sclkRise)
					begin
						next_state.bitCount = 6'h01;
						next_state.isRead   = sdiLive;
						next_state.readActive = sdiLive & ~lockOnly;
						next_state.dataBit  = 1'b0;
						next_state.phase    = PH_ADDR;
					end
				end
				PH_ADDR:
				begin
					if (sclkRise)
					begin
						next_state.addr = {cur.addr[ADDR_W-2:0], sdiLive};
						next_state.bitCount = cur.bitCount + 6'h01;
						if (cur.bitCount == LAST_ADDR_COUNT)
							next_state.phase = PH_DATA;
					end
				end
				PH_DATA:
				begin
					if (sclkRise)
					begin
						next_state.bitCount = cur.bitCount + 6'h01;
						if (cur.bitCount == COMPLETE_COUNT)
						begin
							next_state.phase = PH_DONE;
							if (!cur.isRead)
							begin
								// write completes on 32nd rise
								if (cur.addr == ADDR_IDENTITY)
									next_state.softResetPulse =
										cur.shift[SOFT_RESET_REGS_BIT];
								else if (cur.addr == ADDR_MUX_CFG)
									next_state.muxCfg = cur.shift;
							end
						end
						else if (cur.isRead)
						begin
							// load on edge 8, then shift msb first
							if (cur.bitCount == FIRST_DATA_COUNT)
							begin
								next_state.dataBit = readValue[DATA_W-1];
								next_state.shift   =
									{readValue[DATA_W-2:0], 1'b0};
							end
							else if (cur.bitCount <= LAST_DATA_COUNT)
							begin
								next_state.dataBit = cur.shift[DATA_W-1];
								next_state.shift   =
									{cur.shift[DATA_W-2:0], 1'b0};
							end
						end
						else
						begin
							next_state.shift = {cur.shift[DATA_W-2:0], sdiLive};
						end
					end
				end
				PH_DONE:
				begin
					// read ends at the 32nd falling edge
					if (sclkFall && cur.readActive)
						next_state.readActive = 1'b0;
				end
				default:
				begin
					next_state.phase    = PH_IDLE;
					next_state.bitCount = '0;
				end
			endcase
		end

		// pin mux, registered
		if (next_state.muxCfg[LOCK_ONLY_BIT])
		begin
			next_state.pin.level = cur.lockSync[1];
			next_state.pin.oe_n  = 1'b0;
		end
		else if (next_state.readActive)
		begin
			next_state.pin.level = next_state.dataBit;
			next_state.pin.oe_n  = 1'b0;
		end
		else if (next_state.muxCfg[AUTO_PIN_SHARE_BIT])
		begin
			next_state.pin.level = cur.lockSync[1];
			next_state.pin.oe_n  = 1'b0;
		end
		else
		begin
			next_state.pin.level = 1'b0;
			next_state.pin.oe_n  = 1'b1;
		end
	end

	// ========================================================
	// state register
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			cur.sclkSync       <= '0;
			cur.selSync        <= '0;
			cur.sdiSync        <= '0;
			cur.lockSync       <= '0;
			cur.phase          <= PH_IDLE;
			cur.bitCount       <= '0;
			cur.isRead         <= 1'b0;
			cur.readActive     <= 1'b0;
			cur.addr           <= '0;
			cur.shift          <= '0;
			cur.dataBit        <= 1'b0;
			cur.muxCfg         <= MUX_CFG_RESET;
			cur.softResetPulse <= 1'b0;
			cur.pin.level      <= 1'b0;
			cur.pin.oe_n       <= 1'b1;
		end
		else
			cur <= next_state;
	end

	// outputs straight from flops
	assign lock_or_readback_pin  = cur.pin.level;
	assign lockOrReadbackPinOe_n = cur.pin.oe_n;
	assign softResetPulse        = cur.softResetPulse;
	assign muxConfig             = cur.muxCfg;

endmodule
`default_nettype wire

// [tb/srb_serial_port_sva.sv]
// assertion checker for the serial port readback block
`timescale 1ns/10ps
`default_nettype none
module srb_serial_port_sva
(
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic serialClock,
	input wire logic serial_select,
	input wire logic serialDataIn,
	input wire logic lock_detect_state,
	input wire logic lock_or_readback_pin,
	input wire logic lockOrReadbackPinOe_n,
	input wire logic softResetPulse,
	input wire logic [srb_pkg::DATA_W-1:0] muxConfig
);
	import srb_pkg::*;
	// ========
	// shorthands for pin drive, lock match and pin mode
	wire logic drv = !lockOrReadbackPinOe_n;
	wire logic same = lock_or_readback_pin == lock_detect_state;
	wire logic [1:0] mode = muxConfig[13:12];
	logic [5:0] edges;
	logic rd;
	// rising serial edges seen in this frame
	always_ff @(posedge ref_clk)
		if (srst || !serial_select)
			edges <= 6'h00;
		else if ($rose(serialClock))
			edges <= edges + 6'h01;
	// direction bit of the frame
	always_ff @(posedge ref_clk)
		if ($rose(serialClock) && edges == 6'h00)
			rd <= serialDataIn;
	// ========
	// properties
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	sequence sRise8;
		$rose(serialClock) && serial_select && edges == 6'h07 && rd;
	endsequence
	sequence sAutoIdle;
		(mode == 2'b01 && !serial_select
			&& $stable(lock_detect_state)) [*6];
	endsequence
	chk_pulse_one: assert property
		(softResetPulse |=> !softResetPulse) else $error("long strobe");
	chk_strobe_clears: assert property
		(softResetPulse |=> muxConfig == 24'h000000) else $error("cfg kept");
	chk_lock_only: assert property
		((muxConfig[13] && $stable(lock_detect_state)) [*6] |-> drv && same)
		else $error("pin not lock");
	chk_idle_release: assert property
		((mode == 2'b00 && !serial_select) [*6] |-> !drv)
		else $error("pin driven idle");
	chk_auto_lock: assert property
		(sAutoIdle |-> drv && same) else $error("auto not lock");
	chk_read_drive: assert property
		(sRise8 ##0 !muxConfig[13] |-> ##5 drv) else $error("no drive");
	chk_write_quiet: assert property
		((mode == 2'b00 && serial_select && edges != 6'h00 && !rd) [*3]
		|-> !drv) else $error("write drove pin");
	chk_read_end: assert property
		($fell(serialClock) && serial_select && edges == 6'h20
		&& mode == 2'b00 |-> ##6 !drv) else $error("pin held");
endmodule
bind srb_serial_port srb_serial_port_sva chk (.ref_clk, .srst,
	.serialClock, .serial_select, .serialDataIn, .lock_detect_state,
	.lock_or_readback_pin, .lockOrReadbackPinOe_n, .softResetPulse,
	.muxConfig);
`default_nettype wire

// [tb/srb_host_model.sv]
// host controller model driving the serial port
`timescale 1ns/10ps
`default_nettype none
module srb_host_model
(
	input wire logic ref_clk,
	input wire logic pinLine,
	output var logic serialClock,
	output var logic serial_select,
	output var logic serialDataIn,
	output var logic done,
	output var logic [23:0] rdata
);
	initial {serialClock, serial_select, serialDataIn, done} = 4'h0;
	// half period of the 80 ns serial clock
	task automatic half;
		repeat (10) @(posedge ref_clk);
	endtask
	// one frame: direction, six address bits, 24 data bits
	task automatic xfer(input logic r, input logic [5:0] a,
		input logic [23:0] d);
		logic [30:0] f;
		f = {r, a, d};
		serial_select <= 1'b1;
		serialDataIn <= f[30];
		half;
		for (int k = 1; k <= 32; k++)
		begin
			serialClock <= 1'b1;
			half;
			serialClock <= 1'b0;
			if (k >= 8 && k <= 31)
				rdata <= {rdata[22:0], pinLine};
			if (k <= 30)
				serialDataIn <= f[30-k];
			half;
		end
		serial_select <= 1'b0;
		done <= r;
		@(posedge ref_clk);
		done <= 1'b0;
		half;
		half;
	endtask
	// write frame cut short: select drops after n rising edges (n <= 30)
	task automatic cut(input logic [5:0] a, input logic [23:0] d,
		input int n);
		logic [30:0] f;
		f = {1'b0, a, d};
		serial_select <= 1'b1;
		serialDataIn <= f[30];
		half;
		for (int k = 1; k <= n; k++)
		begin
			serialClock <= 1'b1;
			half;
			serialClock <= 1'b0;
			serialDataIn <= f[30-k];
			half;
		end
		serial_select <= 1'b0;
		half;
		half;
	endtask
endmodule
`default_nettype wire

// [tb/serial_port_readback_bench.sv]
// self-checking bench for the serial port readback block
`timescale 1ns/10ps
`default_nettype none
module serial_port_readback_bench;
	import srb_pkg::*;
	localparam logic [23:0] ID = 24'h3c96e1; // arbitrary identity
	logic ref_clk, srst, lock, sclk, sel, sdi, pin, oeN, pulse, done;
	logic [23:0] cfg, rdata, w;
	logic [23:0] expQ[$];
	int errors = 0, n_tests = 0, ticks = 0;
	int pulses = 0;
	wire pinLine = oeN ? 1'bz : pin;
	srb_serial_port #(.IDENTITY_VALUE(ID)) DUT (.ref_clk, .srst,
		.serialClock(sclk), .serial_select(sel), .serialDataIn(sdi),
		.lock_detect_state(lock), .lock_or_readback_pin(pin),
		.lockOrReadbackPinOe_n(oeN), .softResetPulse(pulse),
		.muxConfig(cfg));
	srb_host_model host (.ref_clk, .pinLine, .serialClock(sclk),
		.serial_select(sel), .serialDataIn(sdi), .done, .rdata);
	// 250 MHz clock
	initial
	begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic [23:0] got, exp);
		n_tests++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value at %0t: %h not %h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// read frame with its expected word noted
	task automatic rd(input logic [5:0] a, input logic [23:0] e);
		expQ.push_back(e);
		host.xfer(1'b1, a, 24'h000000);
	endtask
	// each returned word against the oldest note
	always @(posedge ref_clk)
		if (done === 1'b1)
			chk(rdata, expQ.pop_front());
	// strobe pulses seen on the design's output
	always @(posedge ref_clk)
		if (pulse === 1'b1)
			pulses <= pulses + 1;
	// hang guard
	always @(posedge ref_clk)
	begin
		ticks <= ticks + 1;
		if (ticks == 20000)
		begin
			errors++;
			tally_and_finish;
		end
	end
	// ========
	// scenarios
	initial
	begin
		srst <= 1'b1;
		lock <= 1'b0;
		void'($urandom(23));
		repeat (12) @(posedge ref_clk);
		srst <= 1'b0;
		repeat (4) @(posedge ref_clk);
		chk(cfg, MUX_CFG_RESET);
		chk(24'({pin, oeN}), 24'h000001);
		rd(ADDR_IDENTITY, ID);
		rd(6'h05, READ_UNMAPPED);
		w = 24'($urandom) & 24'hffcfff | 24'h001000;
		host.xfer(1'b0, ADDR_MUX_CFG, w);
		chk(cfg, w);
		chk(24'({pin, oeN}), 24'h000000);
		host.xfer(1'b0, 6'h05, ~w);
		chk(cfg, w);
		chk(24'(pulses), 24'h000000);
		rd(ADDR_MUX_CFG, w);
		lock <= 1'b1;
		host.xfer(1'b0, ADDR_MUX_CFG, w | 24'h002000);
		chk(24'({pin, oeN}), 24'h000002);
		rd(ADDR_IDENTITY, 24'hffffff);
		host.xfer(1'b0, ADDR_IDENTITY, 24'h000001);
		chk(cfg, MUX_CFG_RESET);
		chk(24'(pulses), 24'h000001);
		host.cut(ADDR_MUX_CFG, 24'h003000, 20);
		chk(cfg, MUX_CFG_RESET);
		rd(ADDR_IDENTITY, ID);
		chk(24'(expQ.size()), 24'h000000);
		tally_and_finish;
	end
endmodule
`default_nettype wire
